// >>> rtl/dcap_regs.vh
// Register map, field positions and codes of the DMA arm and priority control block
`ifndef DCAP_REGS_VH
`define DCAP_REGS_VH
`define DCAP_ADDR_ARM 8'hd6
`define DCAP_ADDR_TRIG 8'hd7
`define DCAP_ADDR_FLAG 8'hd1
`define DCAP_ARM_RESET 8'h00
`define DCAP_ABORT_BIT 7
`define DCAP_PRIO_LOW 2'h0
`define DCAP_PRIO_NORMAL 2'h1
`define DCAP_PRIO_HIGH 2'h2
`define DCAP_LEN_FIX0 3'h0
`define DCAP_LEN_FIX7 3'h7
`endif

// >>> rtl/dcap_arbiter.v
// Memory port arbiter between the CPU core and the DMA engine
`timescale 1ns/100ps
`default_nettype none
`include "dcap_regs.vh"
module dcap_arbiter
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire dma_req_i,
  input wire cpu_req_i,
  input wire [1:0] prio_i,
  output reg dma_win_o,
  output reg cpu_win_o
);
  // Set after DMA loses a contention under normal priority
  reg lost_q;
  reg lost_d;

  // Winner selection; reserved code falls back to low priority
  always @*
  begin
    dma_win_o = 1'b0;
    cpu_win_o = cpu_req_i;
    lost_d = lost_q;
    if (dma_req_i && !cpu_req_i)
    begin
      dma_win_o = 1'b1;
    end
    else if (dma_req_i && cpu_req_i)
    begin
      case (prio_i)
        `DCAP_PRIO_HIGH:
        begin
          dma_win_o = 1'b1;
          cpu_win_o = 1'b0;
        end
        `DCAP_PRIO_NORMAL:
        begin
          dma_win_o = lost_q;
          cpu_win_o = ~lost_q;
          lost_d = ~lost_q;
        end
        default:
        begin
          dma_win_o = 1'b0;
          cpu_win_o = 1'b1;
        end
      endcase
    end
  end

  // Loss memory only moves on contention, so alternation is strict
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      lost_q <= 1'b0;
    else
      lost_q <= lost_d;
  end
endmodule // dcap_arbiter
`default_nettype wire

// >>> rtl/dcap_ctrl.v
// Five-channel DMA arm, abort, trigger, length and priority control
`timescale 1ns/100ps
`default_nettype none
`include "dcap_regs.vh"
module dcap_ctrl
#(
  parameter NCH = 5,
  parameter LEN_W = 13
)
(
  input wire clk_sys_i,
  input wire rst_i,
  // Special-function register port
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  // Per-channel descriptor fields, channel c at bits of slice c
  input wire [NCH-1:0] channel_irq_enable_i,
  input wire [NCH-1:0] length_seven_bit_select_i,
  input wire [NCH-1:0] transfer_width_select_i,
  input wire [NCH-1:0] repeat_mode_i,
  input wire [3*NCH-1:0] variable_length_mode_i,
  input wire [2*NCH-1:0] priority_i,
  input wire [LEN_W*NCH-1:0] fixed_length_i,
  // Trigger pulses from peripherals
  input wire [NCH-1:0] trigger_i,
  // Shared memory port
  input wire cpu_req_i,
  output wire cpu_gnt_o,
  input wire [7:0] mem_rdata_i,
  output wire dma_gnt_o,
  output wire [2:0] dma_chan_o,
  // Status
  output reg [NCH-1:0] count_done_o,
  output wire dma_irq_o
);
  // Software-visible registers, the internal peripheral trigger latch, and their next values
  reg [NCH-1:0] channel_arm_bits_q;
  reg [NCH-1:0] channel_arm_bits_d;
  reg [NCH-1:0] manual_trigger_bits_q;
  reg [NCH-1:0] manual_trigger_bits_d;
  reg [NCH-1:0] hw_trig_q;
  reg [NCH-1:0] hw_trig_d;
  reg [NCH-1:0] channel_done_flag_q;
  reg [NCH-1:0] channel_done_flag_d;
  // Completion pulse and read data ahead of their registers
  reg [NCH-1:0] count_done_d;
  reg [7:0] sfr_rdata_d;
  // Per-channel events, one bit per channel
  wire [NCH-1:0] reach;
  wire [NCH-1:0] pend;
  wire [NCH-1:0] gnt_vec;
  // Register write decodes
  wire wr_arm;
  wire wr_trig;
  wire wr_flag;
  wire abort_wr;
  wire [NCH-1:0] abort_sel;
  wire dma_win;
  reg [2:0] sel_idx;
  reg any_pend;
  integer i;

  // Address decode of the three registers of this block
  assign wr_arm = sfr_wr_i && (sfr_addr_i == `DCAP_ADDR_ARM);
  assign wr_trig = sfr_wr_i && (sfr_addr_i == `DCAP_ADDR_TRIG);
  assign wr_flag = sfr_wr_i && (sfr_addr_i == `DCAP_ADDR_FLAG);
  // Abort uses the channel positions of the same write as its selection
  assign abort_wr = wr_arm && sfr_wdata_i[`DCAP_ABORT_BIT];
  assign abort_sel = abort_wr ? sfr_wdata_i[NCH-1:0] : {NCH{1'b0}};

  // A channel asks for the bus only while armed and triggered
  assign pend = channel_arm_bits_q & (hw_trig_q | manual_trigger_bits_q);

  // Lowest channel number has the bus among DMA channels
  always @*
  begin
    sel_idx = 3'h0;
    any_pend = 1'b0;
    for (i = NCH - 1; i >= 0; i = i - 1)
    begin
      if (pend[i])
      begin
        sel_idx = i[2:0];
        any_pend = 1'b1;
      end
    end
  end

  // CPU against DMA under the selected channel priority
  dcap_arbiter u_arb
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .dma_req_i(any_pend),
    .cpu_req_i(cpu_req_i),
    .prio_i(priority_i[2*sel_idx +: 2]),
    .dma_win_o(dma_win),
    .cpu_win_o(cpu_gnt_o)
  );

  assign dma_gnt_o = dma_win;
  assign dma_chan_o = sel_idx;

  // Per-channel transfer counting and length capture
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1)
    begin : g_ch
      // Fixed-length codes bypass the length byte altogether
      wire [2:0] len_mode;
      wire var_len_on;
      wire seven;
      wire [LEN_W-1:0] src_len;
      wire [LEN_W-1:0] cur_len;
      wire [LEN_W-1:0] cnt_nx;
      // Beat counter, length of the current run and first-beat marker
      reg [LEN_W-1:0] cnt_q;
      reg [LEN_W-1:0] len_q;
      reg first_q;

      assign len_mode = variable_length_mode_i[3*c +: 3];
      assign var_len_on = (len_mode != `DCAP_LEN_FIX0) && (len_mode != `DCAP_LEN_FIX7);
      // Word transfers always use the full byte
      assign seven = length_seven_bit_select_i[c] && !transfer_width_select_i[c];
      assign src_len = seven ? {{(LEN_W-7){1'b0}}, mem_rdata_i[6:0]} :
                       {{(LEN_W-8){1'b0}}, mem_rdata_i};
      // First beat of a variable run reads its own length from the source
      assign cur_len = (first_q && var_len_on) ? src_len :
                       (first_q ? fixed_length_i[LEN_W*c +: LEN_W] : len_q);
      assign cnt_nx = cnt_q + {{(LEN_W-1){1'b0}}, 1'b1};
      assign gnt_vec[c] = dma_win && (sel_idx == c);
      // Zero length ends at the first beat rather than wrapping
      assign reach[c] = gnt_vec[c] && (cnt_nx >= cur_len);

      // Counter restarts on abort or completion so the next run re-reads its length
      always @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          cnt_q <= {LEN_W{1'b0}};
          len_q <= {LEN_W{1'b0}};
          first_q <= 1'b1;
        end
        else if (abort_sel[c] || reach[c])
        begin
          cnt_q <= {LEN_W{1'b0}};
          first_q <= 1'b1;
        end
        else if (gnt_vec[c])
        begin
          cnt_q <= cnt_nx;
          len_q <= cur_len;
          first_q <= 1'b0;
        end
      end
    end
  endgenerate

  // Next arm state: hardware disarm first, then a plain software write, abort last.
  // A software write wins over the hardware disarm of the same cycle, so a channel
  // re-armed by the CPU just as it finishes stays armed; abort is never undone.
  always @*
  begin
    channel_arm_bits_d = channel_arm_bits_q;
    // Count reached in single-shot modes disarms the channel
    channel_arm_bits_d = channel_arm_bits_d & ~(reach & ~repeat_mode_i);
    if (wr_arm && !abort_wr)
    begin
      // Only the channel positions are stored, so bits 6 and 5 are dropped
      channel_arm_bits_d = sfr_wdata_i[NCH-1:0];
    end
    channel_arm_bits_d = channel_arm_bits_d & ~abort_sel;
  end

  // Next trigger state: consumed by the grant and dropped by abort.
  // Peripheral pulses are held until granted, so a long CPU burst loses none;
  // the cost is that a pulse seen while unarmed fires once the channel is armed.
  always @*
  begin
    hw_trig_d = (hw_trig_q & ~gnt_vec & ~abort_sel) | trigger_i;
    manual_trigger_bits_d = manual_trigger_bits_q & ~gnt_vec & ~abort_sel;
    if (wr_trig)
    begin
      // A set in the granting cycle survives the clear and asks for another beat
      manual_trigger_bits_d = manual_trigger_bits_d | sfr_wdata_i[NCH-1:0];
    end
  end

  // Next flag state: writing 0 clears a flag, writing 1 leaves it alone.
  // A count reached in the same cycle as the clear wins, so no completion is lost.
  always @*
  begin
    channel_done_flag_d = channel_done_flag_q;
    if (wr_flag)
    begin
      channel_done_flag_d = channel_done_flag_q & sfr_wdata_i[NCH-1:0];
    end
    channel_done_flag_d = channel_done_flag_d | reach;
  end

  // Completion pulse, shown the cycle after the last beat of a channel
  always @*
  begin
    count_done_d = reach;
  end

  // Arm register
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      channel_arm_bits_q <= {NCH{1'b0}};
    end
    else
    begin
      channel_arm_bits_q <= channel_arm_bits_d;
    end
  end

  // Pending trigger registers, manual and peripheral
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      manual_trigger_bits_q <= {NCH{1'b0}};
      hw_trig_q <= {NCH{1'b0}};
    end
    else
    begin
      manual_trigger_bits_q <= manual_trigger_bits_d;
      hw_trig_q <= hw_trig_d;
    end
  end

  // Done flags and the completion pulse
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      channel_done_flag_q <= {NCH{1'b0}};
      count_done_o <= {NCH{1'b0}};
    end
    else
    begin
      channel_done_flag_q <= channel_done_flag_d;
      count_done_o <= count_done_d;
    end
  end

  // Interrupt request only for flags whose channel has its mask bit set
  assign dma_irq_o = |(channel_done_flag_q & channel_irq_enable_i);

  // Read multiplexer; abort and unused bits always read 0
  always @*
  begin
    case (sfr_addr_i)
      `DCAP_ADDR_ARM: sfr_rdata_d = {3'h0, channel_arm_bits_q};
      `DCAP_ADDR_TRIG: sfr_rdata_d = {3'h0, manual_trigger_bits_q};
      `DCAP_ADDR_FLAG: sfr_rdata_d = {3'h0, channel_done_flag_q};
      default: sfr_rdata_d = 8'h00;
    endcase
  end

  // Read data registered one cycle after the strobe and held until the next read,
  // so a slow bus master may sample it late
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sfr_rdata_o <= `DCAP_ARM_RESET;
    end
    else if (sfr_rd_i)
    begin
      sfr_rdata_o <= sfr_rdata_d;
    end
  end
endmodule // dcap_ctrl
`default_nettype wire

// >>> verification/dcap_cpu_model.sv
// CPU core model sharing the memory port
`timescale 1ns/100ps
`default_nettype none
module dcap_cpu_model
(
  input wire logic busy_i,
  input wire logic dma_gnt_i,
  output logic cpu_req_o,
  output logic [7:0] mem_rdata_o
);
  // CPU asks for memory while busy; the length byte is the first source byte
  assign cpu_req_o = busy_i;
  // Inverse off-beat, so a stale byte never passes for data
  assign mem_rdata_o = dma_gnt_i ? 8'h82 : 8'h7d;
endmodule // dcap_cpu_model
`default_nettype wire

// >>> verification/dcap_ctrl_chk.sv
// Port checker of the DMA arm and priority control
`timescale 1ns/100ps
`default_nettype none
module dcap_ctrl_chk
#(parameter NCH = 5)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [NCH-1:0] channel_irq_enable_i,
  input wire logic [2*NCH-1:0] priority_i,
  input wire logic cpu_req_i,
  input wire logic cpu_gnt_o,
  input wire logic dma_gnt_o,
  input wire logic [2:0] dma_chan_o,
  input wire logic [NCH-1:0] count_done_o,
  input wire logic dma_irq_o
);
  // Priority of the channel asking for the bus
  wire logic [1:0] pr = priority_i[2*dma_chan_o+:2];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_cpu_free: assert property (!dma_gnt_o |-> cpu_gnt_o == cpu_req_i)
    else $error("cpu refused");
  chk_one_owner: assert property (!(dma_gnt_o && cpu_gnt_o))
    else $error("two owners");
  chk_low_defer: assert property (cpu_req_i && pr == 2'h0 |-> !dma_gnt_o)
    else $error("low beat won");
  chk_norm_alt: assert property (cpu_req_i && dma_gnt_o && pr == 2'h1
    |=> !(cpu_req_i && dma_gnt_o && pr == 2'h1)) else $error("no alternation");
  chk_done_beat: assert property (|count_done_o |-> $past(dma_gnt_o))
    else $error("done without beat");
  chk_irq_raise: assert property (|(count_done_o & channel_irq_enable_i) |-> dma_irq_o)
    else $error("irq missing");
  chk_irq_mask: assert property (dma_irq_o |-> |channel_irq_enable_i)
    else $error("masked irq");
  chk_unused_zero: assert property (sfr_rd_i |=> sfr_rdata_o[7:5] == 3'h0)
    else $error("unused bits set");
endmodule // dcap_ctrl_chk
bind dcap_ctrl dcap_ctrl_chk #(.NCH(NCH)) i_chk (.clk_sys_i, .rst_i, .sfr_rd_i, .sfr_rdata_o,
  .channel_irq_enable_i, .priority_i, .cpu_req_i, .cpu_gnt_o, .dma_gnt_o, .dma_chan_o,
  .count_done_o, .dma_irq_o);
`default_nettype wire

// >>> verification/dcap_ctrl_bench.sv
// Bench of the DMA arm and priority control
`timescale 1ns/100ps
`default_nettype none
module dcap_ctrl_bench;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, busy = 1'b0, g, d;
  logic [7:0] sfr_addr_i = 8'h0, sfr_wdata_i = 8'h0;
  logic [4:0] channel_irq_enable_i = 5'h01, length_seven_bit_select_i = 5'h18;
  logic [4:0] transfer_width_select_i = 5'h10, repeat_mode_i = 5'h02, trigger_i = 5'h0;
  logic [14:0] variable_length_mode_i = 15'h1200;
  logic [9:0] priority_i = 10'h292;
  logic [64:0] fixed_length_i = {13'h1, 13'h1, 13'h1, 13'h1, 13'h2};
  wire logic [7:0] sfr_rdata_o, mem_rdata_i;
  wire logic [4:0] count_done_o;
  wire logic [2:0] dma_chan_o;
  wire logic cpu_req_i, cpu_gnt_o, dma_gnt_o, dma_irq_o;
  int fail_count = 0, tests_run = 0, cyc = 0;
  // 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;
  dcap_ctrl i_dut (.clk_sys_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .channel_irq_enable_i, .length_seven_bit_select_i, .transfer_width_select_i,
    .repeat_mode_i, .variable_length_mode_i, .priority_i, .fixed_length_i, .trigger_i,
    .cpu_req_i, .cpu_gnt_o, .mem_rdata_i, .dma_gnt_o, .dma_chan_o, .count_done_o, .dma_irq_o);
  dcap_cpu_model i_cpu (.busy_i(busy), .dma_gnt_i(dma_gnt_o), .cpu_req_o(cpu_req_i),
    .mem_rdata_o(mem_rdata_i));
  task end_sim;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // Strobes drop a whole cycle before the next access
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= v;
    sfr_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    sfr_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    sfr_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(sfr_rdata_o, exp);
  endtask
  // Waits n cycles for a beat of channel c; d is its done pulse
  task wt(input logic [7:0] c, input int n);
    g = 1'b0;
    d = 1'b0;
    repeat (n)
    begin
      @(negedge clk_sys_i);
      if (!g && dma_gnt_o === 1'b1)
      begin
        g = 1'b1;
        chk({5'h0, dma_chan_o}, c);
        @(negedge clk_sys_i);
        d = count_done_o[c];
      end
    end
  endtask
  task bt(input logic [7:0] c, input int n);
    wr(8'hd7, 8'h01 << c);
    wt(c, n);
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      end_sim;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(8'hd6, 8'h00);
    wr(8'hd6, 8'h7f);
    rd(8'hd6, 8'h1f);
    wr(8'hd6, 8'h83);
    rd(8'hd6, 8'h1c);
    wr(8'hd6, 8'h1f);
    busy <= 1'b1;
    bt(8'h0, 3);
    chk({6'h0, g, d}, 8'h02);
    bt(8'h0, 3);
    chk({5'h0, g, d, dma_irq_o}, 8'h07);
    rd(8'hd1, 8'h01);
    rd(8'hd6, 8'h1e);
    rd(8'hd7, 8'h00);
    wr(8'hd1, 8'h00);
    bt(8'h1, 6);
    chk({6'h0, g, d}, 8'h00);
    @(posedge clk_sys_i);
    busy <= 1'b0;
    wt(8'h1, 3);
    chk({5'h0, g, d, dma_irq_o}, 8'h06);
    rd(8'hd1, 8'h02);
    @(posedge clk_sys_i);
    busy <= 1'b1;
    bt(8'h2, 2);
    chk({6'h0, g, d}, 8'h03);
    bt(8'h3, 3);
    bt(8'h3, 3);
    chk({6'h0, g, d}, 8'h03);
    bt(8'h4, 3);
    bt(8'h4, 3);
    chk({6'h0, g, d}, 8'h02);
    rd(8'hd6, 8'h12);
    wr(8'hd6, 8'h90);
    rd(8'hd6, 8'h02);
    bt(8'h0, 6);
    chk({7'h0, g}, 8'h00);
    end_sim;
  end
endmodule // dcap_ctrl_bench
`default_nettype wire
